// *** src/prod_test_port.sv ***
`timescale 1ns/1ps

`include "prod_test_cfg.svh"

// What this block does
// - In test mode the 12-bit test address chooses the register that a tester access targets.
// - In test mode the test address is taken from receive pins 21 down to 10.
// - Register select high steers an access to test registers, low to normal registers.
// - In test mode the register select, also address bit 12, is taken from receive pin 24.
// - While the read strobe is low and the write strobe high in test mode the block drives the addressed register onto test data.
// - In test mode the read strobe is taken from receive pin 22.
// - On the rising edge of the write strobe, with the read strobe high, the test data is written into the addressed register.
// - In test mode the write strobe is taken from receive pin 23.
// - In test mode the bidirectional test data bus uses transmit pins 31 down to 16.

module prod_test_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic prod_test_enable,
  input wire logic [`PT_RX_W-1:0] rx_data_pins,
  input wire logic [`PT_DATA_W-1:0] test_data_in,
  output logic [`PT_TX_W-1:0] tx_data_pins_out,
  output logic [`PT_TX_W-1:0] tx_data_pins_oe,
  output logic [`PT_RX_W-1:0] rx_data_core,
  input wire logic [`PT_TX_W-1:0] tx_data_core,
  output logic test_mode,
  output prod_test_pkg::test_addr_t reg_addr,
  output logic reg_test_sel,
  output logic reg_rd,
  output logic reg_wr,
  output prod_test_pkg::test_data_t reg_wdata,
  input wire prod_test_pkg::test_data_t reg_rdata
);
  import prod_test_pkg::*;

  pin_sample_if pins ();

  // Pin inputs into the core clock domain
  pin_sync u_sync (
    .clock(clock),
    .rst(rst),
    .prod_test_enable(prod_test_enable),
    .rx_data_pins(rx_data_pins),
    .test_data_in(test_data_in),
    .pins(pins.src)
  );

  // Decoded views of the synchronised pins
  logic en_s;
  logic read_n_s;
  logic write_n_s;
  logic sel_s;
  test_addr_t addr_s;
  test_data_t tdat_s;
  logic write_n_prev_r;

  assign en_s = pins.sample.enable;
  assign read_n_s = pins.sample.rx[`PT_READ_BIT];
  assign write_n_s = pins.sample.rx[`PT_WRITE_BIT];
  assign sel_s = pins.sample.rx[`PT_SEL_BIT];
  assign addr_s = pins.sample.rx[`PT_ADDR_MSB:`PT_ADDR_LSB];
  assign tdat_s = pins.sample.tdat;

  // True for the shared receive bit positions taken over in test mode
  function automatic logic shared_rx_bit(input int unsigned idx);
    shared_rx_bit = (idx >= `PT_ADDR_LSB) && (idx <= `PT_SEL_BIT);
  endfunction

  // True for the transmit bit positions that carry test data
  function automatic logic shared_tx_bit(input int unsigned idx);
    shared_tx_bit = (idx >= `PT_TDAT_LSB) && (idx <= `PT_TDAT_MSB);
  endfunction

  access_state_e state_r;
  access_state_e state_nxt;
  logic write_rise;

  // Write strobe edge, seen only after both flops settled
  assign write_rise = write_n_s && !write_n_prev_r;

  // Previous synced write strobe, idle high after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      write_n_prev_r <= 1'b1;
    end else begin
      write_n_prev_r <= write_n_s;
    end
  end

  // Access sequencing; a write needs a seen low phase before its rise
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ACC_IDLE: begin
        if (en_s && !read_n_s && write_n_s) begin
          state_nxt = ACC_READ;
        end else if (en_s && !write_n_s && read_n_s) begin
          state_nxt = ACC_WRITE;
        end
      end
      ACC_READ: begin
        // read lasts while strobe stays low
        if (!en_s || read_n_s || !write_n_s) begin
          state_nxt = ACC_IDLE;
        end
      end
      ACC_WRITE: begin
        if (!en_s || write_n_s || !read_n_s) begin
          state_nxt = ACC_IDLE;
        end
      end
      default: begin
        state_nxt = ACC_IDLE;
      end
    endcase
  end

  // Access state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ACC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Test mode flag seen by the core
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      test_mode <= 1'b0;
    end else begin
      test_mode <= en_s;
    end
  end

  // address follows pins during test mode, held while in the write state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_addr <= `PT_ADDR_RST;
      reg_test_sel <= 1'b0;
    end else if (en_s && state_r != ACC_WRITE) begin
      reg_addr <= addr_s;
      reg_test_sel <= sel_s;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_wr <= 1'b0;
      reg_wdata <= `PT_DATA_RST;
    end else begin
      // Cleared every cycle, so a committed rise gives a one-cycle pulse
      reg_wr <= 1'b0;
      if (state_r == ACC_WRITE && en_s && read_n_s && write_rise) begin
        reg_wr <= 1'b1;
        reg_wdata <= tdat_s;
      end
    end
  end

  // Address and select held steady through the write low phase
  logic wr_addr_hold;
  assign wr_addr_hold = (state_r == ACC_WRITE);

  // One read decode feeds the core request and the pin drive alike
  logic read_active;
  assign read_active = en_s && !read_n_s && write_n_s && !wr_addr_hold;

  // read request level for the core
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rd <= 1'b0;
    end else begin
      reg_rd <= read_active;
    end
  end

  // Transmit pin drive; test data replaces the upper half in test mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_data_pins_out <= `PT_TX_RST;
      tx_data_pins_oe <= {`PT_TX_W{1'b1}};
    end else begin
      // Enables follow the read decode, in step with the core request
      for (int i = 0; i < `PT_TX_W; i++) begin
        if (en_s && shared_tx_bit(i)) begin
          // upper transmit pins carry test data
          tx_data_pins_out[i] <= reg_rdata[4'(i - `PT_TDAT_LSB)];  // Index cut to data width
          // released unless a read is under way
          tx_data_pins_oe[i] <= read_active;
        end else begin
          tx_data_pins_out[i] <= tx_data_core[i];
          tx_data_pins_oe[i] <= 1'b1;
        end
      end
    end
  end

  // Receive data to the core; test pins read as zero in test mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_data_core <= `PT_RX_RST;
    end else begin
      // Bits outside the shared range pass straight through
      for (int i = 0; i < `PT_RX_W; i++) begin
        // normal role when enable is low
        rx_data_core[i] <= (en_s && shared_rx_bit(i)) ? 1'b0 : pins.sample.rx[i];
      end
    end
  end
endmodule

// *** inc/prod_test_cfg.svh ***
`ifndef PROD_TEST_CFG_SVH
`define PROD_TEST_CFG_SVH

// Pin group widths
`define PT_RX_W 32
`define PT_TX_W 32
`define PT_ADDR_W 12
`define PT_DATA_W 16

// Shared receive pin positions used in test mode
`define PT_ADDR_LSB 10
`define PT_ADDR_MSB 21
`define PT_READ_BIT 22
`define PT_WRITE_BIT 23
`define PT_SEL_BIT 24

// Shared transmit pin positions carrying test data
`define PT_TDAT_LSB 16
`define PT_TDAT_MSB 31

// Reset values
`define PT_TX_RST 32'hFFFFFFFF
`define PT_RX_RST 32'h00000000
`define PT_DATA_RST 16'h0000
`define PT_ADDR_RST 12'h000

`endif

// *** inc/prod_test_pkg.sv ***
`include "prod_test_cfg.svh"

package prod_test_pkg;

  // Raw pin levels sampled into the core clock domain
  typedef struct packed {
    logic enable;
    logic [`PT_RX_W-1:0] rx;
    logic [`PT_DATA_W-1:0] tdat;
  } pin_sample_s;

  // Tester access sequencing
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READ,
    ACC_WRITE
  } access_state_e;

  typedef logic [`PT_ADDR_W-1:0] test_addr_t;
  typedef logic [`PT_DATA_W-1:0] test_data_t;

endpackage

// *** inc/pin_sample_if.sv ***
`timescale 1ns/1ps

interface pin_sample_if;
  import prod_test_pkg::*;

  pin_sample_s sample;

  modport src (
    output sample
  );
  modport sink (
    input sample
  );
endinterface

// *** src/pin_sync.sv ***
`timescale 1ns/1ps

`include "prod_test_cfg.svh"

module pin_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic prod_test_enable,
  input wire logic [`PT_RX_W-1:0] rx_data_pins,
  input wire logic [`PT_DATA_W-1:0] test_data_in,
  pin_sample_if.src pins
);
  import prod_test_pkg::*;

  pin_sample_s meta_r;
  pin_sample_s sync_r;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= '{enable: prod_test_enable, rx: rx_data_pins, tdat: test_data_in};
      sync_r <= meta_r;
    end
  end

  assign pins.sample = sync_r;
endmodule

// *** test/prod_test_port_properties.sv ***
`timescale 1ns/1ps

module prod_test_port_properties
  import prod_test_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] rx_data_pins,
  input wire test_data_t test_data_in,
  input wire logic [31:0] tx_data_pins_out,
  input wire logic [31:0] tx_data_pins_oe,
  input wire logic test_mode,
  input wire test_addr_t reg_addr,
  input wire logic reg_test_sel,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire test_data_t reg_wdata,
  input wire test_data_t reg_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Write strobe low phase, then rise with read high
  sequence s_wr;
    (test_mode && rx_data_pins[22] && !rx_data_pins[23]) [*4] ##1 (rx_data_pins[22] && rx_data_pins[23]);
  endsequence
  // Both strobes held low
  sequence s_both;
    (!rx_data_pins[22] && !rx_data_pins[23]) [*4];
  endsequence

  property p_wr; s_wr |-> ##[1:4] reg_wr; endproperty
  property p_wr_once; reg_wr |=> !reg_wr; endproperty
  property p_wdata; reg_wr |-> reg_wdata == $past(test_data_in, 3); endproperty
  property p_oe; reg_rd |-> tx_data_pins_oe[31:16] == 16'hFFFF; endproperty
  property p_rdata; reg_rd && $past(reg_rd) |-> tx_data_pins_out[31:16] == $past(reg_rdata); endproperty
  property p_release; test_mode && $past(test_mode) && !reg_rd |-> tx_data_pins_oe[31:16] == 16'h0000; endproperty
  property p_addr; reg_rd |-> reg_addr == rx_data_pins[21:10] && reg_test_sel == rx_data_pins[24]; endproperty
  property p_both; s_both |-> !reg_rd && !reg_wr; endproperty
  property p_normal; !test_mode |-> !reg_rd && !reg_wr && tx_data_pins_oe == 32'hFFFFFFFF; endproperty

  a_wr: assert property (p_wr) else $error("write lost");
  a_wr_once: assert property (p_wr_once) else $error("write pulse long");
  a_wdata: assert property (p_wdata) else $error("write data wrong");
  a_oe: assert property (p_oe) else $error("read not driven");
  a_rdata: assert property (p_rdata) else $error("read data wrong");
  a_release: assert property (p_release) else $error("bus not released");
  a_addr: assert property (p_addr) else $error("address wrong");
  a_both: assert property (p_both) else $error("both strobes taken");
  a_normal: assert property (p_normal) else $error("access in normal mode");
endmodule

bind prod_test_port prod_test_port_properties i_props (.*);

// *** test/core_reg_model.sv ***
`timescale 1ns/1ps

module core_reg_model
  import prod_test_pkg::*;
(
  input wire logic clock,
  input wire prod_test_pkg::test_addr_t reg_addr,
  input wire logic reg_test_sel,
  input wire logic reg_wr,
  input wire prod_test_pkg::test_data_t reg_wdata,
  output prod_test_pkg::test_data_t reg_rdata
);
  test_data_t mem_r [8];

  always_ff @(posedge clock) begin
    if (reg_wr) begin
      mem_r[{reg_test_sel, reg_addr[1:0]}] <= reg_wdata;
    end
  end

  // Full address folded in so every bit matters
  assign reg_rdata = mem_r[{reg_test_sel, reg_addr[1:0]}] ^ {4'h0, reg_addr};
endmodule

// *** test/prod_test_port_tb.sv ***
`timescale 1ns/1ps

module prod_test_port_tb;
  import prod_test_pkg::*;
  typedef struct packed {
    logic s;
    test_addr_t a;
    test_data_t d;
    test_data_t e;
  } row_s;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic prod_test_enable = 1'b0;
  logic [31:0] rx_data_pins = 32'h00C00000;
  logic [31:0] tx_data_core = 32'h89ABCDEF;
  test_data_t tester_d = 16'h0000;
  test_data_t test_data_in;
  logic [31:0] tx_data_pins_out, tx_data_pins_oe, rx_data_core;
  logic test_mode, reg_test_sel, reg_rd, reg_wr;
  test_addr_t reg_addr;
  test_data_t reg_wdata, reg_rdata;
  int checks = 0;
  int n_mismatch = 0;
  row_s rows [5] = '{'{1'b0, 12'h000, 16'hA5A5, 16'hA5A5}, '{1'b1, 12'hFFD, 16'h1234, 16'h1DC9},
    '{1'b0, 12'h802, 16'h0000, 16'h0802}, '{1'b1, 12'h003, 16'hFFFF, 16'hFFFC}, '{1'b1, 12'h400, 16'h5A5A, 16'h5E5A}};

  // Shared data wire seen by the device input
  assign test_data_in = tx_data_pins_oe[16] ? tx_data_pins_out[31:16] : tester_d;

  prod_test_port i_dut (.clock(clock), .rst(rst), .prod_test_enable(prod_test_enable),
    .rx_data_pins(rx_data_pins), .test_data_in(test_data_in), .tx_data_pins_out(tx_data_pins_out),
    .tx_data_pins_oe(tx_data_pins_oe), .rx_data_core(rx_data_core), .tx_data_core(tx_data_core),
    .test_mode(test_mode), .reg_addr(reg_addr), .reg_test_sel(reg_test_sel), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  core_reg_model i_core (.clock(clock), .reg_addr(reg_addr), .reg_test_sel(reg_test_sel),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Core clock
  initial begin
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic drive(input logic s, input logic w, input logic r, input test_addr_t a, input int n);
    @(negedge clock);
    rx_data_pins = {7'h00, s, w, r, a, 10'h000};
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input row_s x);
    tester_d = x.d;
    drive(x.s, 1'b1, 1'b1, x.a, 4);
    drive(x.s, 1'b0, 1'b1, x.a, 4);
    drive(x.s, 1'b1, 1'b1, x.a, 6);
  endtask
  task automatic rd(input row_s x);
    drive(x.s, 1'b1, 1'b1, x.a, 4);
    drive(x.s, 1'b1, 1'b0, x.a, 6);
    chk(tx_data_pins_oe[31:16], 16'hFFFF, "read drive");
    chk(tx_data_pins_out[31:16], x.e, "read data");
    chk(rx_data_core[24:10], 15'h0000, "rx masked");
    drive(x.s, 1'b1, 1'b1, x.a, 6);
    chk(tx_data_pins_oe[31:16], 16'h0000, "release");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog, about ten times the expected run
  initial begin
    #15000;
    n_mismatch++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    chk(tx_data_pins_out, 32'hFFFFFFFF, "reset tx");
    chk(tx_data_pins_oe, 32'hFFFFFFFF, "reset oe");
    chk({rx_data_core[30:0], test_mode}, 32'h00000000, "reset core");
    rst = 1'b0;
    prod_test_enable = 1'b1;
    repeat (6) @(negedge clock);
    $display("test reset done");
    foreach (rows[i]) wr(rows[i]);
    foreach (rows[i]) rd(rows[i]);
    $display("test table done");
    tester_d = 16'hDEAD;
    drive(1'b0, 1'b1, 1'b1, 12'h000, 4);
    drive(1'b0, 1'b0, 1'b0, 12'h000, 6);
    chk(tx_data_pins_oe[31:16], 16'h0000, "both low");
    drive(1'b0, 1'b1, 1'b1, 12'h000, 6);
    rd(rows[0]);
    $display("test refusal done");
    rst = 1'b1;
    repeat (2) @(negedge clock);
    chk(tx_data_pins_oe, 32'hFFFFFFFF, "mid reset oe");
    chk({reg_rd, reg_wr, test_mode}, 32'h00000000, "mid reset ctl");
    rst = 1'b0;
    repeat (6) @(negedge clock);
    rd(rows[0]);
    $display("test mid reset done");
    prod_test_enable = 1'b0;
    rx_data_pins = 32'h01234567;
    repeat (6) @(negedge clock);
    chk(test_mode, 1'b0, "mode off");
    chk(rx_data_core, 32'h01234567, "normal rx");
    chk(tx_data_pins_out, tx_data_core, "normal tx");
    chk(tx_data_pins_oe, 32'hFFFFFFFF, "normal oe");
    $display("test normal done");
    report_and_stop;
  end
endmodule
